// ==== laco_exec.sv ====
// laco_exec: execution slice for logic, arithmetic and control operations
`timescale 1ns/10ps
module laco_exec (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // operation request
  input wire logic OP_VALID,
  input wire logic [7:0] OP_CODE,
  input wire logic [1:0] OP_PAIR,
  input wire logic OP_IDX_Y,
  input wire logic [7:0] OP_DATA,
  input wire logic [7:0] OP_DISP,
  output logic OP_BUSY,
  output logic OP_DONE,
  // register preset
  input wire logic LD_VALID,
  input wire logic [2:0] LD_SEL,
  input wire logic [15:0] LD_DATA,
  // memory read
  output logic MEM_RD,
  output logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  // interrupt side
  input wire logic INT_REQ,
  input wire logic [7:0] INT_DATA,
  input wire logic [7:0] INT_VEC_REG,
  output logic INT_ACK,
  output logic [15:0] INT_TARGET,
  output logic INT_BUS_EXEC,
  output logic IRQ_ENABLE_FLIPFLOP,
  output logic [1:0] IRQ_MODE,
  output logic HALTED,
  // architectural registers
  output logic [7:0] ACC,
  output logic [7:0] FLAGS,
  output logic [15:0] BC,
  output logic [15:0] DE,
  output logic [15:0] HL,
  output logic [15:0] SP,
  output logic [15:0] IX,
  output logic [15:0] IY
);

  laco_pkg::laco_state_t state; // sequencer state
  logic [7:0] op; // latched operation
  logic [1:0] pair; // latched pair code
  logic idx_y; // latched index choice
  logic [7:0] opnd; // latched immediate byte
  logic [4:0] cnt; // states left in the operation
  logic ei_block; // enable waits one instruction
  logic [2:0] irq_sync; // request synchroniser
  logic irq_lvl; // filtered request level
  logic go; // request taken this cycle
  logic commit; // last state, results land
  logic take_irq; // interrupt accepted this cycle
  logic load; // preset taken this cycle
  logic carry_flag; // carry alias
  logic sub_flag; // subtract alias
  logic [6:0] upper_flags; // every flag but carry
  logic [15:0] idx_cur; // index register picked by the latched choice
  logic [15:0] rr; // selected pair operand
  logic [15:0] rb; // second addend of wide op
  logic [15:0] pv; // stepped pair value
  logic [15:0] idx_addr; // indexed address at request
  logic [17:0] ws; // {half, carry, sum}
  logic [8:0] t1; // decimal adjust low step
  logic [8:0] t2; // decimal adjust high step
  logic lo_fix; // low digit needs six
  logic hi_fix; // high digit needs six
  logic wsub; // wide op subtracts
  logic [7:0] next_acc;
  logic [7:0] next_flags;
  logic [15:0] next_bc;
  logic [15:0] next_de;
  logic [15:0] next_hl;
  logic [15:0] next_sp;
  logic [15:0] next_ix;
  logic [15:0] next_iy;

  // cycles taken by each operation, zero for an unknown select
  function automatic logic [4:0] op_cycles(input logic [7:0] c);
    int st;
    st = 0;
    case (c)
      laco_pkg::XOR_ACC_OP, laco_pkg::XOR_IMMEDIATE_OP: st = laco_pkg::CNT_XOR_MEM;
      laco_pkg::XOR_INDEXED_OP: st = laco_pkg::CNT_XOR_IDX;
      laco_pkg::DECIMAL_ADJUST_OP, laco_pkg::ACC_INVERT_OP, laco_pkg::CARRY_INVERT_OP,
      laco_pkg::CARRY_SET_OP, laco_pkg::HALT_OP, laco_pkg::IRQ_ENABLE_OP,
      laco_pkg::IRQ_DISABLE_OP: st = laco_pkg::CNT_SHORT;
      laco_pkg::ACC_NEGATE_OP, laco_pkg::IRQ_MODE_ZERO_OP, laco_pkg::IRQ_MODE_ONE_OP,
      laco_pkg::IRQ_MODE_TWO_OP: st = laco_pkg::CNT_TWO_CYCLE;
      laco_pkg::WIDE_ADD_OP: st = laco_pkg::CNT_WIDE_ADD;
      laco_pkg::WIDE_ADD_CARRY_OP, laco_pkg::WIDE_SUB_BORROW_OP,
      laco_pkg::INDEX_ADD_OP: st = laco_pkg::CNT_WIDE_CARRY;
      laco_pkg::PAIR_INCREMENT_OP, laco_pkg::PAIR_DECREMENT_OP: st = laco_pkg::CNT_PAIR_STEP;
      laco_pkg::INDEX_INCREMENT_OP: st = laco_pkg::CNT_INDEX_INC;
      default: st = 0;
    endcase
    op_cycles = 5'(st * laco_pkg::CYC_PER_STATE);
  endfunction

  // sign, zero and parity of a byte; other flag bits zero
  function automatic logic [7:0] szp(input logic [7:0] r);
    szp = 8'h00;
    szp[laco_pkg::F_S] = r[7];
    szp[laco_pkg::F_Z] = (r == 8'h00);
    szp[laco_pkg::F_PV] = ~^r;
  endfunction

  // 16-bit add with carry out of bit 11 and bit 15; sum wraps
  function automatic logic [17:0] wide_add(input logic [15:0] a, input logic [15:0] b,
                                           input logic cin);
    logic [16:0] s;
    logic [12:0] h;
    s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    h = {1'b0, a[11:0]} + {1'b0, b[11:0]} + {12'h000, cin};
    wide_add = {h[12], s};
  endfunction

  assign carry_flag = FLAGS[laco_pkg::F_C];
  assign sub_flag = FLAGS[laco_pkg::F_N];
  assign upper_flags = FLAGS[7:1];
  assign idx_cur = idx_y ? IY : IX;
  assign idx_addr = (OP_IDX_Y ? IY : IX) + {{8{OP_DISP[7]}}, OP_DISP};
  // halted core only wakes by interrupt; acceptance waits for the op boundary
  assign take_irq = irq_lvl && IRQ_ENABLE_FLIPFLOP && !ei_block && state != laco_pkg::SQ_EXEC;
  assign go = OP_VALID && state == laco_pkg::SQ_IDLE && !take_irq && op_cycles(OP_CODE) != 5'h00;
  assign commit = state == laco_pkg::SQ_EXEC && cnt == 5'h01;
  assign load = LD_VALID && state != laco_pkg::SQ_EXEC && !go;

  // pair operand; code two means the index itself for index add
  always_comb begin
    case (pair)
      2'h0: rr = BC;
      2'h1: rr = DE;
      2'h2: rr = (op == laco_pkg::INDEX_ADD_OP) ? idx_cur : HL;
      default: rr = SP;
    endcase
  end

  // result and flag datapath, applied only at commit
  always_comb begin
    next_acc = ACC;
    next_flags = FLAGS;
    next_bc = BC;
    next_de = DE;
    next_hl = HL;
    next_sp = SP;
    next_ix = IX;
    next_iy = IY;
    wsub = (op == laco_pkg::WIDE_SUB_BORROW_OP);
    rb = wsub ? ~rr : rr;
    ws = 18'h00000;
    pv = (op == laco_pkg::PAIR_INCREMENT_OP) ? rr + 16'h0001 : rr - 16'h0001;
    lo_fix = (ACC[3:0] > 4'h9) || FLAGS[laco_pkg::F_H];
    t1 = {1'b0, ACC} + (lo_fix ? 9'h006 : 9'h000);
    hi_fix = (t1[7:4] > 4'h9) || carry_flag || t1[8];
    t2 = t1 + (hi_fix ? 9'h060 : 9'h000);
    case (op)
      // memory and indexed forms use the fetched byte
      laco_pkg::XOR_ACC_OP, laco_pkg::XOR_INDEXED_OP: begin
        next_acc = ACC ^ MEM_RDATA;
        next_flags = szp(ACC ^ MEM_RDATA);
      end
      laco_pkg::XOR_IMMEDIATE_OP: begin
        next_acc = ACC ^ opnd;
        next_flags = szp(ACC ^ opnd);
      end
      laco_pkg::DECIMAL_ADJUST_OP: begin
        next_acc = t2[7:0];
        next_flags = szp(t2[7:0]);
        next_flags[laco_pkg::F_H] = ACC[3:0] > 4'h9;
        next_flags[laco_pkg::F_N] = sub_flag;
        next_flags[laco_pkg::F_C] = hi_fix || t2[8];
      end
      laco_pkg::ACC_INVERT_OP: begin
        next_acc = ~ACC;
        next_flags[laco_pkg::F_H] = 1'b1;
        next_flags[laco_pkg::F_N] = 1'b1;
      end
      laco_pkg::ACC_NEGATE_OP: begin
        next_acc = 8'h00 - ACC;
        next_flags = szp(8'h00 - ACC);
        next_flags[laco_pkg::F_H] = ACC[3:0] != 4'h0;
        next_flags[laco_pkg::F_PV] = ACC == 8'h80;
        next_flags[laco_pkg::F_N] = 1'b1;
        next_flags[laco_pkg::F_C] = ACC != 8'h00;
      end
      laco_pkg::CARRY_INVERT_OP: next_flags[laco_pkg::F_C] = ~carry_flag;
      laco_pkg::CARRY_SET_OP: next_flags[laco_pkg::F_C] = 1'b1;
      laco_pkg::WIDE_ADD_OP: begin
        ws = wide_add(HL, rr, 1'b0);
        next_hl = ws[15:0];
        next_flags[laco_pkg::F_H] = ws[17];
        next_flags[laco_pkg::F_N] = 1'b0;
        next_flags[laco_pkg::F_C] = ws[16];
      end
      // subtract is add of the inverted pair with inverted carry in
      laco_pkg::WIDE_ADD_CARRY_OP, laco_pkg::WIDE_SUB_BORROW_OP: begin
        ws = wide_add(HL, rb, wsub ^ carry_flag);
        next_hl = ws[15:0];
        next_flags = 8'h00;
        next_flags[laco_pkg::F_S] = ws[15];
        next_flags[laco_pkg::F_Z] = ws[15:0] == 16'h0000;
        next_flags[laco_pkg::F_H] = ws[17] ^ wsub;
        next_flags[laco_pkg::F_PV] = (HL[15] == rb[15]) && (ws[15] != HL[15]);
        next_flags[laco_pkg::F_N] = wsub;
        next_flags[laco_pkg::F_C] = ws[16];
      end
      laco_pkg::INDEX_ADD_OP: begin
        ws = wide_add(idx_cur, rr, 1'b0);
        next_ix = idx_y ? IX : ws[15:0];
        next_iy = idx_y ? ws[15:0] : IY;
        next_flags[laco_pkg::F_H] = ws[17];
        next_flags[laco_pkg::F_N] = 1'b0;
        next_flags[laco_pkg::F_C] = ws[16];
      end
      laco_pkg::PAIR_INCREMENT_OP, laco_pkg::PAIR_DECREMENT_OP: begin
        case (pair)
          2'h0: next_bc = pv;
          2'h1: next_de = pv;
          2'h2: next_hl = pv;
          default: next_sp = pv;
        endcase
      end
      laco_pkg::INDEX_INCREMENT_OP: begin
        next_ix = idx_y ? IX : IX + 16'h0001;
        next_iy = idx_y ? IY + 16'h0001 : IY;
      end
      default: next_acc = ACC;
    endcase
  end

  // request pin: three stages, level changes when the last two agree
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      irq_sync <= 3'h0;
      irq_lvl <= 1'b0;
    end else begin
      irq_sync <= {irq_sync[1:0], INT_REQ};
      if (irq_sync[1] == irq_sync[2]) begin
        irq_lvl <= irq_sync[2];
      end
    end
  end

  // sequencer: one core clock per state, halt parks until interrupt
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= laco_pkg::SQ_IDLE;
      op <= 8'h00;
      pair <= 2'h0;
      idx_y <= 1'b0;
      opnd <= 8'h00;
      cnt <= 5'h00;
      OP_BUSY <= 1'b0;
      OP_DONE <= 1'b0;
      HALTED <= 1'b0;
    end else begin
      OP_DONE <= commit;
      case (state)
        laco_pkg::SQ_IDLE: begin
          if (go) begin
            state <= laco_pkg::SQ_EXEC;
            op <= OP_CODE;
            pair <= OP_PAIR;
            idx_y <= OP_IDX_Y;
            opnd <= OP_DATA;
            cnt <= op_cycles(OP_CODE) - 5'h01;
            OP_BUSY <= 1'b1;
          end
        end
        laco_pkg::SQ_EXEC: begin
          cnt <= cnt - 5'h01;
          if (commit) begin
            OP_BUSY <= 1'b0;
            if (op == laco_pkg::HALT_OP) begin
              state <= laco_pkg::SQ_HALT;
              HALTED <= 1'b1;
            end else begin
              state <= laco_pkg::SQ_IDLE;
            end
          end
        end
        laco_pkg::SQ_HALT: begin
          if (take_irq) begin
            state <= laco_pkg::SQ_IDLE;
            HALTED <= 1'b0;
          end
        end
        default: state <= laco_pkg::SQ_IDLE;
      endcase
    end
  end

  // memory read held from request until the commit edge samples the byte
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      MEM_RD <= 1'b0;
      MEM_ADDR <= laco_pkg::PAIR_RST;
    end else if (go) begin
      MEM_RD <= OP_CODE == laco_pkg::XOR_ACC_OP || OP_CODE == laco_pkg::XOR_INDEXED_OP;
      MEM_ADDR <= (OP_CODE == laco_pkg::XOR_INDEXED_OP) ? idx_addr : HL;
    end else if (commit) begin
      MEM_RD <= 1'b0;
    end
  end

  // interrupt enable, mode and acceptance
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      IRQ_ENABLE_FLIPFLOP <= 1'b0;
      ei_block <= 1'b0;
      IRQ_MODE <= laco_pkg::IM_ZERO;
      INT_ACK <= 1'b0;
      INT_TARGET <= laco_pkg::PAIR_RST;
      INT_BUS_EXEC <= 1'b0;
    end else begin
      INT_ACK <= take_irq;
      INT_BUS_EXEC <= take_irq && IRQ_MODE == laco_pkg::IM_ZERO;
      if (take_irq) begin
        IRQ_ENABLE_FLIPFLOP <= 1'b0;
        case (IRQ_MODE)
          laco_pkg::IM_ONE: INT_TARGET <= laco_pkg::RESTART_TARGET;
          laco_pkg::IM_TWO: INT_TARGET <= {INT_VEC_REG, INT_DATA};
          default: INT_TARGET <= {8'h00, INT_DATA};
        endcase
      end else if (commit) begin
        // the block lifts once the instruction after enable completes
        ei_block <= op == laco_pkg::IRQ_ENABLE_OP;
        case (op)
          laco_pkg::IRQ_ENABLE_OP: IRQ_ENABLE_FLIPFLOP <= 1'b1;
          laco_pkg::IRQ_DISABLE_OP: IRQ_ENABLE_FLIPFLOP <= 1'b0;
          laco_pkg::IRQ_MODE_ZERO_OP: IRQ_MODE <= laco_pkg::IM_ZERO;
          laco_pkg::IRQ_MODE_ONE_OP: IRQ_MODE <= laco_pkg::IM_ONE;
          laco_pkg::IRQ_MODE_TWO_OP: IRQ_MODE <= laco_pkg::IM_TWO;
          default: IRQ_MODE <= IRQ_MODE;
        endcase
      end
    end
  end

  // architectural registers: results at commit, presets when not executing
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ACC <= laco_pkg::ACC_RST;
      FLAGS <= laco_pkg::FLAGS_RST;
      BC <= laco_pkg::PAIR_RST;
      DE <= laco_pkg::PAIR_RST;
      HL <= laco_pkg::PAIR_RST;
      SP <= laco_pkg::PAIR_RST;
      IX <= laco_pkg::PAIR_RST;
      IY <= laco_pkg::PAIR_RST;
    end else if (commit) begin
      ACC <= next_acc;
      FLAGS <= next_flags;
      BC <= next_bc;
      DE <= next_de;
      HL <= next_hl;
      SP <= next_sp;
      IX <= next_ix;
      IY <= next_iy;
    end else if (load) begin
      case (LD_SEL)
        laco_pkg::LD_BC: BC <= LD_DATA;
        laco_pkg::LD_DE: DE <= LD_DATA;
        laco_pkg::LD_HL: HL <= LD_DATA;
        laco_pkg::LD_SP: SP <= LD_DATA;
        laco_pkg::LD_IX: IX <= LD_DATA;
        laco_pkg::LD_IY: IY <= LD_DATA;
        laco_pkg::LD_AF: begin
          ACC <= LD_DATA[15:8];
          FLAGS <= LD_DATA[7:0];
        end
        default: ACC <= ACC;
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_go(logic [7:0] code);
    go && OP_CODE == code;
  endsequence

  a_xor_mem_result: assert property (s_go(laco_pkg::XOR_ACC_OP) |-> ##7
    (OP_DONE && ACC == ($past(ACC) ^ $past(MEM_RDATA)) && !carry_flag))
    else $error("memory xor result or timing wrong");
  a_xor_imm_result: assert property (s_go(laco_pkg::XOR_IMMEDIATE_OP) |-> ##7
    (OP_DONE && ACC == ($past(ACC, 7) ^ $past(OP_DATA, 7)) && !FLAGS[laco_pkg::F_H]))
    else $error("immediate xor result or timing wrong");
  a_xor_idx_addr: assert property (s_go(laco_pkg::XOR_INDEXED_OP) |=>
    (MEM_RD && MEM_ADDR == $past(idx_addr)) ##18 OP_DONE)
    else $error("indexed xor address or timing wrong");
  a_daa_low_fix: assert property (s_go(laco_pkg::DECIMAL_ADJUST_OP) ##0 (ACC == 8'h0a
    && !carry_flag) |-> ##4 (OP_DONE && ACC == 8'h10))
    else $error("decimal adjust low digit wrong");
  a_daa_high_fix: assert property (s_go(laco_pkg::DECIMAL_ADJUST_OP) ##0 (ACC == 8'ha0
    && !FLAGS[laco_pkg::F_H]) |-> ##4
    (ACC == 8'h00 && carry_flag && sub_flag == $past(sub_flag, 4)))
    else $error("decimal adjust high digit wrong");
  a_acc_invert: assert property (s_go(laco_pkg::ACC_INVERT_OP) |-> ##4
    (OP_DONE && ACC == ~$past(ACC, 4)))
    else $error("invert result or timing wrong");
  a_acc_negate: assert property (s_go(laco_pkg::ACC_NEGATE_OP) |-> ##8
    (OP_DONE && ACC == 8'h00 - $past(ACC, 8) && sub_flag))
    else $error("negate result or timing wrong");
  a_carry_invert: assert property (s_go(laco_pkg::CARRY_INVERT_OP) |-> ##4
    (carry_flag != $past(carry_flag, 4) && upper_flags == $past(upper_flags, 4)))
    else $error("carry invert wrong");
  a_carry_set: assert property (s_go(laco_pkg::CARRY_SET_OP) |-> ##4
    (OP_DONE && carry_flag && upper_flags == $past(upper_flags, 4)))
    else $error("carry set wrong");
  a_halt_park: assert property (s_go(laco_pkg::HALT_OP) |-> ##4
    (HALTED && ACC == $past(ACC, 4) && !OP_BUSY))
    else $error("halt did not park");
  a_enable_late: assert property (s_go(laco_pkg::IRQ_ENABLE_OP) |-> ##4
    (IRQ_ENABLE_FLIPFLOP && ei_block) ##1 !INT_ACK)
    else $error("enable took effect too early");
  a_disable_now: assert property (s_go(laco_pkg::IRQ_DISABLE_OP) |-> ##4
    (!IRQ_ENABLE_FLIPFLOP && !INT_ACK))
    else $error("disable did not act");
  a_mode_one_target: assert property (INT_ACK && IRQ_MODE == laco_pkg::IM_ONE |->
    INT_TARGET == laco_pkg::RESTART_TARGET && !INT_BUS_EXEC)
    else $error("mode one target wrong");
  a_wide_add_time: assert property (s_go(laco_pkg::WIDE_ADD_OP) |-> ##10 OP_DONE)
    else $error("wide add timing wrong");
  a_pair_flags_kept: assert property (s_go(laco_pkg::PAIR_INCREMENT_OP) |-> ##6
    (OP_DONE && FLAGS == $past(FLAGS, 6)))
    else $error("pair increment timing or flags wrong");

endmodule // laco_exec

// ==== laco_pkg.sv ====
// laco_pkg: op selects, state counts, flag layout and reset values
package laco_pkg;
  // operation selects on OP_CODE; interrupt control uses its opcode bytes
  localparam logic [7:0] XOR_ACC_OP = 8'h01;
  localparam logic [7:0] XOR_IMMEDIATE_OP = 8'h02;
  localparam logic [7:0] XOR_INDEXED_OP = 8'h03;
  localparam logic [7:0] DECIMAL_ADJUST_OP = 8'h04;
  localparam logic [7:0] ACC_INVERT_OP = 8'h05;
  localparam logic [7:0] ACC_NEGATE_OP = 8'h06;
  localparam logic [7:0] CARRY_INVERT_OP = 8'h07;
  localparam logic [7:0] CARRY_SET_OP = 8'h08;
  localparam logic [7:0] HALT_OP = 8'h09;
  localparam logic [7:0] WIDE_ADD_OP = 8'h0a;
  localparam logic [7:0] WIDE_ADD_CARRY_OP = 8'h0b;
  localparam logic [7:0] WIDE_SUB_BORROW_OP = 8'h0c;
  localparam logic [7:0] INDEX_ADD_OP = 8'h0d;
  localparam logic [7:0] PAIR_INCREMENT_OP = 8'h0e;
  localparam logic [7:0] PAIR_DECREMENT_OP = 8'h0f;
  localparam logic [7:0] INDEX_INCREMENT_OP = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OP = 8'hfb;
  localparam logic [7:0] IRQ_DISABLE_OP = 8'hf3;
  localparam logic [7:0] IRQ_MODE_ZERO_OP = 8'h46;
  localparam logic [7:0] IRQ_MODE_ONE_OP = 8'h56;
  localparam logic [7:0] IRQ_MODE_TWO_OP = 8'h5e;
  // clock states per operation
  localparam int CNT_XOR_MEM = 7;
  localparam int CNT_XOR_IDX = 19;
  localparam int CNT_SHORT = 4;
  localparam int CNT_TWO_CYCLE = 8;
  localparam int CNT_WIDE_ADD = 10;
  localparam int CNT_WIDE_CARRY = 15;
  localparam int CNT_PAIR_STEP = 6;
  localparam int CNT_INDEX_INC = 10;
  // one state lasts one 40 ns period of the 25 MHz core clock
  localparam int CLK_NS = 40;
  localparam int STATE_NS = 40;
  localparam int CYC_PER_STATE = STATE_NS / CLK_NS;
  // flag bit positions
  localparam int F_S = 7;
  localparam int F_Z = 6;
  localparam int F_H = 4;
  localparam int F_PV = 2;
  localparam int F_N = 1;
  localparam int F_C = 0;
  // register preset selects
  localparam logic [2:0] LD_BC = 3'h0;
  localparam logic [2:0] LD_DE = 3'h1;
  localparam logic [2:0] LD_HL = 3'h2;
  localparam logic [2:0] LD_SP = 3'h3;
  localparam logic [2:0] LD_IX = 3'h4;
  localparam logic [2:0] LD_IY = 3'h5;
  localparam logic [2:0] LD_AF = 3'h6;
  // reset values and fixed restart target
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PAIR_RST = 16'h0000;
  localparam logic [15:0] RESTART_TARGET = 16'h0038;
  // interrupt modes and sequencer states
  typedef enum logic [1:0] {IM_ZERO, IM_ONE, IM_TWO} laco_imode_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_EXEC, SQ_HALT} laco_state_t;
endpackage

// ==== laco_env.sv ====
// laco_env: memory and interrupting device model for the exec slice
`timescale 1ns/10ps
module laco_env (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // memory side
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  // interrupter side
  input wire logic fire,
  input wire logic [7:0] byte_in,
  input wire logic int_ack,
  output logic int_req,
  output logic [7:0] int_data
);
  logic tick; // idle pattern, flips every cycle
  // released lines toggle so stale data can never pass for a match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick <= 1'b0;
    else tick <= ~tick;
  end
  // request level held until the processor acknowledges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) int_req <= 1'b0;
    else if (int_ack) int_req <= 1'b0;
    else if (fire) int_req <= 1'b1;
  end
  // byte driven only while requesting
  assign int_data = int_req ? byte_in : {8{tick}};
  // memory content derived from the address
  assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ 8'h5a) : {8{tick}};
endmodule // laco_env

// ==== logic_arith_control_ops_tb_top.sv ====
// logic_arith_control_ops_tb_top: self-checking bench for the exec slice
`timescale 1ns/10ps
module logic_arith_control_ops_tb_top;
  logic clk = 1'b0, rst = 1'b1, opv = 1'b0, ldv = 1'b0, idy = 1'b0, fire = 1'b0;
  logic [7:0] opc = 8'h00, opd = 8'h00, dsp = 8'h00, vec = 8'h00, ib = 8'h00;
  logic [1:0] pr = 2'h0;
  logic [2:0] lds = 3'h0;
  logic [15:0] ldd = 16'h0000;
  logic busy, done, mrd, ack, bex, ien, halt_op, irq;
  logic [7:0] mrdat, idat, acc, fl;
  logic [15:0] madr, tgt, bc, de, hl, sp, ix, iy;
  logic [1:0] imode;
  int err_count = 0;
  int compares = 0;
  // 25 MHz core clock
  always #20 clk = ~clk;
  laco_exec i_dut (
    .CORE_CLK(clk), .RST(rst), .OP_VALID(opv), .OP_CODE(opc), .OP_PAIR(pr),
    .OP_IDX_Y(idy), .OP_DATA(opd), .OP_DISP(dsp), .OP_BUSY(busy), .OP_DONE(done),
    .LD_VALID(ldv), .LD_SEL(lds), .LD_DATA(ldd), .MEM_RD(mrd), .MEM_ADDR(madr),
    .MEM_RDATA(mrdat), .INT_REQ(irq), .INT_DATA(idat), .INT_VEC_REG(vec),
    .INT_ACK(ack), .INT_TARGET(tgt), .INT_BUS_EXEC(bex), .IRQ_ENABLE_FLIPFLOP(ien),
    .IRQ_MODE(imode), .HALTED(halt_op), .ACC(acc), .FLAGS(fl), .BC(bc), .DE(de),
    .HL(hl), .SP(sp), .IX(ix), .IY(iy));
  laco_env i_env (.clk(clk), .rst(rst), .mem_rd(mrd), .mem_addr(madr), .mem_rdata(mrdat),
    .fire(fire), .byte_in(ib), .int_ack(ack), .int_req(irq), .int_data(idat));
  // single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  // register preset, strobe dropped a full cycle before any reuse
  task automatic ld(input logic [2:0] s, input logic [15:0] d);
    lds = s;
    ldd = d;
    ldv = 1'b1;
    @(negedge clk) ldv = 1'b0;
    @(negedge clk);
  endtask
  // one operation; request held until busy, length counted to done
  task automatic op(input logic [7:0] c, input logic [1:0] p, input int n);
    int k;
    opc = c;
    pr = p;
    opv = 1'b1;
    for (k = 1; k < 40; k++) begin
      @(negedge clk);
      if (busy === 1'b1) opv = 1'b0;
      if (done === 1'b1) break;
    end
    chk(k, n, "op length");
  endtask
  // raise a request and expect it taken with the given target
  task automatic irq_take(input logic [7:0] b, input logic [15:0] t, input logic x);
    int k;
    ib = b;
    fire = 1'b1;
    @(negedge clk) fire = 1'b0;
    for (k = 0; k < 12 && ack !== 1'b1; k++) @(negedge clk);
    chk({ack, ien, bex, tgt}, {1'b1, 1'b0, x, t}, "int accept");
  endtask
  // raise a request and expect it ignored for ten cycles
  task automatic irq_quiet();
    logic s = 1'b0;
    ib = 8'hc7;
    fire = 1'b1;
    @(negedge clk) fire = 1'b0;
    repeat (10) @(negedge clk) s = s | ack;
    chk(s, 0, "int taken early");
  endtask
  // xor forms: immediate, memory at hl, indexed with negative offset
  task automatic t_xor();
    ld(laco_pkg::LD_AF, 16'h3c13);
    ld(laco_pkg::LD_HL, 16'h1234);
    opd = 8'h0f;
    op(laco_pkg::XOR_IMMEDIATE_OP, 2'h0, 7);
    chk({acc, fl & 8'h11}, 16'h3300, "xor imm");
    ld(laco_pkg::LD_AF, 16'h3311);
    op(laco_pkg::XOR_ACC_OP, 2'h0, 7);
    chk({madr, acc, fl & 8'h11}, 32'h12345d00, "xor hl");
    ld(laco_pkg::LD_IY, 16'h2000);
    idy = 1'b1;
    dsp = 8'hfe;
    op(laco_pkg::XOR_INDEXED_OP, 2'h0, 19);
    chk({madr, acc}, 24'h1ffef9, "xor idx");
  endtask
  // decimal adjust: both nibble fixes, then half-carry path; n kept
  task automatic t_daa();
    ld(laco_pkg::LD_AF, 16'h9a02);
    op(laco_pkg::DECIMAL_ADJUST_OP, 2'h0, 4);
    chk({acc, fl[laco_pkg::F_C], fl[laco_pkg::F_N]}, 10'h003, "daa high");
    ld(laco_pkg::LD_AF, 16'h2212);
    op(laco_pkg::DECIMAL_ADJUST_OP, 2'h0, 4);
    chk({acc, fl[laco_pkg::F_N]}, 9'h051, "daa low");
    ld(laco_pkg::LD_AF, 16'h0a00);
    op(laco_pkg::DECIMAL_ADJUST_OP, 2'h0, 4);
    chk(acc, 8'h10, "daa low digit");
    ld(laco_pkg::LD_AF, 16'ha000);
    op(laco_pkg::DECIMAL_ADJUST_OP, 2'h0, 4);
    chk({acc, fl[laco_pkg::F_C]}, 9'h001, "daa high digit");
  endtask
  // accumulator invert and negate, carry invert and set
  task automatic t_acc();
    ld(laco_pkg::LD_AF, 16'h5a00);
    op(laco_pkg::ACC_INVERT_OP, 2'h0, 4);
    chk(acc, 8'ha5, "invert");
    op(laco_pkg::ACC_NEGATE_OP, 2'h0, 8);
    chk({acc, fl[laco_pkg::F_N]}, 9'h0b7, "negate");
    ld(laco_pkg::LD_AF, 16'h12d5);
    op(laco_pkg::CARRY_INVERT_OP, 2'h0, 4);
    chk(fl, 8'hd4, "carry invert");
    op(laco_pkg::CARRY_SET_OP, 2'h0, 4);
    chk(fl, 8'hd5, "carry set");
  endtask
  // sixteen-bit add, carry forms, index add and pair steps with wrap
  task automatic t_wide();
    logic [7:0] f0;
    ld(laco_pkg::LD_AF, 16'h0000);
    ld(laco_pkg::LD_HL, 16'hffff);
    ld(laco_pkg::LD_BC, 16'h0001);
    ld(laco_pkg::LD_DE, 16'h1233);
    op(laco_pkg::WIDE_ADD_OP, 2'h0, 10);
    chk({hl, fl[laco_pkg::F_C]}, 17'h00001, "wide add");
    ld(laco_pkg::LD_AF, 16'h0003);
    op(laco_pkg::WIDE_ADD_CARRY_OP, 2'h1, 15);
    chk({hl, fl[laco_pkg::F_N]}, 17'h02468, "add carry");
    op(laco_pkg::WIDE_SUB_BORROW_OP, 2'h1, 15);
    chk({hl, fl[laco_pkg::F_N], fl[laco_pkg::F_C]}, 18'h00007, "sub borrow");
    ld(laco_pkg::LD_IX, 16'h0f00);
    ld(laco_pkg::LD_BC, 16'h0100);
    idy = 1'b0;
    op(laco_pkg::INDEX_ADD_OP, 2'h0, 15);
    chk({ix, fl & 8'h11}, 24'h100010, "index add");
    f0 = fl;
    ld(laco_pkg::LD_SP, 16'hffff);
    op(laco_pkg::PAIR_INCREMENT_OP, 2'h3, 6);
    chk({sp, fl}, {16'h0000, f0}, "pair inc");
    op(laco_pkg::PAIR_DECREMENT_OP, 2'h0, 6);
    chk({bc, fl}, {16'h00ff, f0}, "pair dec");
    ld(laco_pkg::LD_IY, 16'hffff);
    idy = 1'b1;
    op(laco_pkg::INDEX_INCREMENT_OP, 2'h0, 10);
    chk({iy, fl}, {16'h0000, f0}, "index inc");
  endtask
  // enable, disable and the three modes; halt woken by an interrupt
  task automatic t_int();
    vec = 8'h12;
    op(laco_pkg::IRQ_MODE_ZERO_OP, 2'h0, 8);
    op(laco_pkg::IRQ_ENABLE_OP, 2'h0, 4);
    op(laco_pkg::IRQ_DISABLE_OP, 2'h0, 4);
    irq_quiet();
    op(laco_pkg::IRQ_ENABLE_OP, 2'h0, 4);
    irq_quiet();
    op(laco_pkg::CARRY_SET_OP, 2'h0, 4);
    irq_take(8'hc7, 16'h00c7, 1'b1);
    op(laco_pkg::IRQ_MODE_ONE_OP, 2'h0, 8);
    op(laco_pkg::IRQ_ENABLE_OP, 2'h0, 4);
    op(laco_pkg::CARRY_SET_OP, 2'h0, 4);
    irq_take(8'h77, 16'h0038, 1'b0);
    op(laco_pkg::IRQ_MODE_TWO_OP, 2'h0, 8);
    chk(imode, 2'h2, "mode two");
    op(laco_pkg::IRQ_ENABLE_OP, 2'h0, 4);
    op(laco_pkg::HALT_OP, 2'h0, 4);
    chk({halt_op, iy}, 17'h10000, "halted");
    irq_take(8'h44, 16'h1244, 1'b0);
    chk(halt_op, 0, "halt left");
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_xor();
    t_daa();
    t_acc();
    t_wide();
    t_int();
    finish_test();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule // logic_arith_control_ops_tb_top
